// ### design/dmsc_mode_ctrl.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// mode pins, lock tracking, loop-through choice and status flags
module dmsc_mode_ctrl
  import dmsc_pkg::*;
(
  input wire logic core_clk, // block and parallel clock
  input wire logic rst_b, // async reset, active low
  // apb slave
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  // asynchronous pins
  input wire logic role_select, // high master, low slave
  input wire logic input_select, // high input one
  input wire logic carrier_detect_one, // high input one invalid
  input wire logic carrier_detect_two, // high input two invalid
  input wire logic bus_width_select, // high 20-bit, low 10-bit
  // two-way mode pins
  input wire logic asi_stream_flag_in, // pin level
  output logic asi_stream_flag_out, // driven level
  output logic asi_stream_flag_oe, // high while driven
  input wire logic rate_select_in, // pin level
  output logic rate_select_out, // driven level
  output logic rate_select_oe, // high while driven
  input wire logic reclock_select_in, // pin level
  output logic reclock_select_out, // driven level
  output logic reclock_select_oe, // high while driven
  input wire logic video_processing_flag_in, // pin level
  output logic video_processing_flag_out, // driven level
  output logic video_processing_flag_oe, // high while driven
  // detection from the datapath, same clock
  input wire logic det_lock, // reclocker locked to a compliant stream
  input wire logic det_asi, // stream is asi
  input wire logic det_sd, // stream is 270Mb/s, else hd rate
  input wire logic anc_luma_det, // ancillary data in luma
  input wire logic anc_chroma_det, // ancillary data in chroma
  // controls to the datapath
  output logic serial_in_one_sel, // high input one, low input two
  output logic loop_reclocked, // high reclocked, low buffered loop
  output logic loop_mute, // loop-through driver muted
  output logic deser_en, // deserializer running
  output logic smpte_proc_en, // descramble and video processing
  output logic asi_align_en, // asi word alignment
  output logic asi_decode_en, // asi 8b/10b decoding
  output logic par_width20, // 20-bit demultiplexed output
  output logic par_mute, // parallel outputs muted
  output logic luma_anc_flag, // luma ancillary flag
  output logic lock_flag // locked flag
);

  logic [DMSC_PIN_W-1:0] pin_raw;
  logic [DMSC_PIN_W-1:0] pin_s;
  logic role_m;
  logic ip_s;
  logic cdet_one_s;
  logic cdet_two_s;
  logic bw_s;
  logic asi_in_s;
  logic rate_in_s;
  logic rc_in_s;
  logic proc_in_s;
  logic carrier_ok;
  logic cfg_asi;
  logic cfg_smpte;
  logic match;
  logic kind_asi;
  logic kind_sd;
  logic rate_eff;
  logic asi_mode;
  logic [3:0] qual_cnt;
  logic [1:0] ctrl;
  logic [DMSC_LOSS_W-1:0] loss_cnt;
  logic [31:0] status;
  logic [31:0] next_rdata;
  logic wr_en;
  logic unmapped;
  logic loss_ev;
  dmsc_lock_e state;
  dmsc_lock_e next_state;

  // all pin inputs pass two flip-flops
  assign pin_raw = {role_select, input_select, carrier_detect_one,
                    carrier_detect_two, bus_width_select,
                    asi_stream_flag_in, rate_select_in,
                    reclock_select_in, video_processing_flag_in};

  dmsc_sync2 #(.W(DMSC_PIN_W)) u_pin_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .d(pin_raw),
    .q(pin_s)
  );

  assign {role_m, ip_s, cdet_one_s, cdet_two_s, bw_s,
          asi_in_s, rate_in_s, rc_in_s, proc_in_s} = pin_s;

  // input and carrier selection
  assign serial_in_one_sel = ip_s;
  assign carrier_ok = ip_s ? !cdet_one_s : !cdet_two_s;

  // slave configuration decoded from the mode pins
  assign cfg_asi = asi_in_s && rate_in_s && !proc_in_s;
  assign cfg_smpte = proc_in_s && !asi_in_s;

  // stream matches the expected type; slave rate follows the synchronised rate pin
  always_comb begin
    if (role_m) begin
      match = det_lock;
      if (state == DMSC_LOCK) begin
        match = det_lock && det_asi == kind_asi && det_sd == kind_sd;
      end
    end else begin
      match = det_lock && det_sd == rate_in_s &&
              ((cfg_asi && det_asi) || (cfg_smpte && !det_asi));
    end
  end

  // lock tracking transitions
  always_comb begin
    next_state = state;
    case (state)
      DMSC_NOSIG: begin
        if (carrier_ok) begin
          next_state = DMSC_SEARCH;
        end
      end
      DMSC_SEARCH: begin
        if (!carrier_ok) begin
          next_state = DMSC_NOSIG;
        end else if (match && qual_cnt == DMSC_QUAL_LAST) begin
          next_state = DMSC_LOCK;
        end
      end
      DMSC_LOCK: begin
        if (!carrier_ok) begin
          next_state = DMSC_NOSIG;
        end else if (!match) begin
          next_state = DMSC_SEARCH;
        end
      end
      default: begin
        next_state = DMSC_NOSIG;
      end
    endcase
  end

  // lock state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= DMSC_NOSIG;
    end else begin
      state <= next_state;
    end
  end

  // qualification counter: match must hold for the full time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      qual_cnt <= 4'h0;
    end else if (state != DMSC_SEARCH || !match) begin
      qual_cnt <= 4'h0;
    end else if (qual_cnt != DMSC_QUAL_LAST) begin
      qual_cnt <= qual_cnt + 4'h1;
    end
  end

  // detected kind captured while searching, held while locked
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      kind_asi <= 1'b0;
      kind_sd <= 1'b0;
    end else if (state == DMSC_SEARCH) begin
      kind_asi <= det_asi;
      kind_sd <= det_sd;
    end
  end

  // effective mode: detected in master, pin-set in slave
  assign rate_eff = role_m ? kind_sd : rate_in_s;
  assign asi_mode = role_m ? (state == DMSC_LOCK && kind_asi) : cfg_asi;

  // status pins driven only in master
  always_comb begin
    asi_stream_flag_oe = role_m;
    rate_select_oe = role_m;
    reclock_select_oe = role_m;
    video_processing_flag_oe = role_m;
    asi_stream_flag_out = state == DMSC_LOCK && kind_asi;
    rate_select_out = kind_sd;
    reclock_select_out = state == DMSC_LOCK;
    video_processing_flag_out = state == DMSC_LOCK && !kind_asi;
  end

  // loop-through source and datapath enables
  assign loop_reclocked = role_m ? (state == DMSC_LOCK)
                                 : rc_in_s;
  assign loop_mute = ctrl[DMSC_CTRL_LOOP_MUTE] || !carrier_ok;
  assign deser_en = role_m ? (state == DMSC_LOCK) : 1'b1;
  assign smpte_proc_en = role_m ? (state == DMSC_LOCK && !kind_asi)
                                : cfg_smpte;
  assign asi_align_en = asi_mode;
  assign asi_decode_en = asi_mode;
  assign par_width20 = bw_s && !asi_mode;
  assign par_mute = !carrier_ok || ctrl[DMSC_CTRL_PAR_MUTE];

  // flags registered on the parallel clock
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_flag <= 1'b0;
      luma_anc_flag <= 1'b0;
    end else begin
      lock_flag <= carrier_ok &&
                   next_state == DMSC_LOCK;
      if (par_mute || asi_mode) begin
        luma_anc_flag <= 1'b0;
      end else if (!rate_eff || bw_s) begin
        luma_anc_flag <= anc_luma_det;
      end else begin
        luma_anc_flag <= anc_luma_det || anc_chroma_det;
      end
    end
  end

  // apb decode; zero wait states
  assign pready = 1'b1;
  assign unmapped = paddr != DMSC_CTRL_OFS && paddr != DMSC_STAT_OFS &&
                    paddr != DMSC_LOSS_OFS;
  assign pslverr = psel && penable && unmapped;
  assign wr_en = psel && penable && pwrite && !unmapped;

  // control register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= DMSC_CTRL_RST;
    end else if (wr_en && paddr == DMSC_CTRL_OFS) begin
      ctrl <= pwdata[1:0];
    end
  end

  // lock loss counter; a loss in the clearing cycle still counts
  assign loss_ev = state == DMSC_LOCK && next_state != DMSC_LOCK;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loss_cnt <= DMSC_LOSS_RST;
    end else if (wr_en && paddr == DMSC_LOSS_OFS) begin
      loss_cnt <= loss_ev ? 8'h01 : DMSC_LOSS_RST;
    end else if (loss_ev && loss_cnt != 8'hFF) begin
      loss_cnt <= loss_cnt + 8'h01;
    end
  end

  // status word
  always_comb begin
    status = 32'h0;
    status[DMSC_ST_MASTER] = role_m;
    status[DMSC_ST_LOCK] = lock_flag;
    status[DMSC_ST_RATE] = rate_eff;
    status[DMSC_ST_ASI] = asi_mode;
    status[DMSC_ST_RECLK] = loop_reclocked;
    status[DMSC_ST_PROC] = smpte_proc_en;
    status[DMSC_ST_INONE] = ip_s;
    status[DMSC_ST_CARRIER] = carrier_ok;
    status[DMSC_ST_LUMA] = luma_anc_flag;
    status[DMSC_ST_W20] = par_width20;
  end

  // read mux sampled in the setup cycle
  always_comb begin
    case (paddr)
      DMSC_CTRL_OFS: next_rdata = {30'h0, ctrl};
      DMSC_STAT_OFS: next_rdata = status;
      DMSC_LOSS_OFS: next_rdata = {24'h0, loss_cnt};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // checks on mode and flag behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // pin level two edges back decides who drives the mode pins
  master_drive_a: assert property (
    ($past(rst_b) && $past(rst_b, 2) && $past(role_select, 2)) |->
      asi_stream_flag_oe && rate_select_oe &&
      reclock_select_oe && video_processing_flag_oe)
    else $error("master does not drive the mode pins");

  slave_release_a: assert property (
    ($past(rst_b) && $past(rst_b, 2) && !$past(role_select, 2)) |->
      !asi_stream_flag_oe && !rate_select_oe &&
      !reclock_select_oe && !video_processing_flag_oe)
    else $error("slave drives a mode pin");

  unlock_buffer_a: assert property (
    (role_m && state != DMSC_LOCK) |-> !loop_reclocked &&
                                       !reclock_select_out)
    else $error("loop reclocked without lock");

  slave_loop_a: assert property (
    (!role_m && !rc_in_s) |-> !loop_reclocked)
    else $error("slave loop not buffered");

  asi_status_a: assert property (
    (role_m && asi_stream_flag_out) |-> state == DMSC_LOCK && kind_asi)
    else $error("asi status without asi lock");

  carrier_lock_a: assert property (
    !carrier_ok |=> !lock_flag ##0 !luma_anc_flag)
    else $error("flags set with invalid carrier");

  lock_qual_a: assert property (
    $rose(lock_flag) |-> $past(match, 1) && $past(match, 8))
    else $error("lock without full qualification");

  mux_luma_a: assert property (
    (!par_mute && !asi_mode && rate_eff && !bw_s && anc_chroma_det)
      |=> luma_anc_flag)
    else $error("10-bit sd chroma ancillary missed");

  hd_luma_a: assert property (
    (!rate_eff && !anc_luma_det) |=> !luma_anc_flag)
    else $error("hd luma flag without luma ancillary");

  slave_asi_off_a: assert property (
    (!role_m && !asi_in_s) |-> !asi_align_en && !asi_decode_en)
    else $error("asi decoding while stream-type low");

  width_asi_a: assert property (
    asi_mode |-> !par_width20)
    else $error("bus width not ignored in asi mode");

endmodule : dmsc_mode_ctrl

// ### design/dmsc_pkg.sv
package dmsc_pkg;

  // register byte offsets
  localparam logic [7:0] DMSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] DMSC_STAT_OFS = 8'h04;
  localparam logic [7:0] DMSC_LOSS_OFS = 8'h08;

  // control field positions and reset value
  localparam int DMSC_CTRL_LOOP_MUTE = 0;
  localparam int DMSC_CTRL_PAR_MUTE = 1;
  localparam logic [1:0] DMSC_CTRL_RST = 2'h0;

  // status field positions
  localparam int DMSC_ST_MASTER = 0;
  localparam int DMSC_ST_LOCK = 1;
  localparam int DMSC_ST_RATE = 2;
  localparam int DMSC_ST_ASI = 3;
  localparam int DMSC_ST_RECLK = 4;
  localparam int DMSC_ST_PROC = 5;
  localparam int DMSC_ST_INONE = 6;
  localparam int DMSC_ST_CARRIER = 7;
  localparam int DMSC_ST_LUMA = 8;
  localparam int DMSC_ST_W20 = 9;
  localparam int DMSC_ST_WIDTH = 10;

  // loss counter width and reset value
  localparam int DMSC_LOSS_W = 8;
  localparam logic [7:0] DMSC_LOSS_RST = 8'h00;

  // lock qualification time and derived cycle count (rounded up)
  localparam int DMSC_CLK_NS = 100;
  localparam int DMSC_QUAL_NS = 800;
  localparam int DMSC_QUAL_CYC =
    (DMSC_QUAL_NS + DMSC_CLK_NS - 1) / DMSC_CLK_NS;
  localparam logic [3:0] DMSC_QUAL_LAST = 4'(DMSC_QUAL_CYC - 1);

  // pin synchroniser width
  localparam int DMSC_PIN_W = 9;

  // lock tracking states
  typedef enum logic [2:0] {
    DMSC_NOSIG = 3'b001,
    DMSC_SEARCH = 3'b010,
    DMSC_LOCK = 3'b100
  } dmsc_lock_e;

endpackage : dmsc_pkg

// ### design/dmsc_sync2.sv
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pin levels
module dmsc_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk, // block clock
  input wire logic rst_b, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : dmsc_sync2

// ### tb/dmsc_app_model.sv
`timescale 1ns/10ps
// application logic on the far side of the two-way mode pins
module dmsc_app_model (
  input wire logic [3:0] cfg, // asi, rate, reclock, processing wanted
  input wire logic [3:0] dev_oe, // device drive enables
  input wire logic [3:0] dev_out, // device driven levels
  output logic [3:0] pin // resolved pin levels
);
  // the app drives a pin only while the device has let it go
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = dev_oe[i] ? dev_out[i] : cfg[i];
    end
  end
endmodule : dmsc_app_model

// ### tb/dmsc_tb.sv
`timescale 1ns/10ps
// self-checking bench for the mode and status control block
module deserializer_mode_status_control_tb;
  import dmsc_pkg::*;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic role, ipsel, cd_one, cd_two, bw, er, sd, asi;
  logic [3:0] cfg, oe, dout, pin;
  logic dlock, dasi, dsd, al, ac, in1, lrc, lmute, desen, pen, aen, den;
  logic w20, pmute, luma, lock;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int e;

  dmsc_mode_ctrl dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .role_select(role),
    .input_select(ipsel), .carrier_detect_one(cd_one),
    .carrier_detect_two(cd_two), .bus_width_select(bw),
    .asi_stream_flag_in(pin[3]), .asi_stream_flag_out(dout[3]),
    .asi_stream_flag_oe(oe[3]), .rate_select_in(pin[2]),
    .rate_select_out(dout[2]), .rate_select_oe(oe[2]),
    .reclock_select_in(pin[1]), .reclock_select_out(dout[1]),
    .reclock_select_oe(oe[1]), .video_processing_flag_in(pin[0]),
    .video_processing_flag_out(dout[0]),
    .video_processing_flag_oe(oe[0]), .det_lock(dlock), .det_asi(dasi),
    .det_sd(dsd), .anc_luma_det(al), .anc_chroma_det(ac),
    .serial_in_one_sel(in1), .loop_reclocked(lrc), .loop_mute(lmute),
    .deser_en(desen), .smpte_proc_en(pen), .asi_align_en(aen),
    .asi_decode_en(den), .par_width20(w20), .par_mute(pmute),
    .luma_anc_flag(luma), .lock_flag(lock)
  );

  dmsc_app_model app_u (.cfg(cfg), .dev_oe(oe), .dev_out(dout), .pin(pin));

  // clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("timeout reached");
      tally_and_finish();
    end
  end

  task automatic go(input int n);
    repeat (n) @(posedge core_clk);
  endtask : go

  // let n edges land, then sample at the falling edge
  task automatic settle(input int n);
    go(n);
    @(negedge core_clk);
  endtask : settle

  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    go(1);
    penable <= 1'b1;
    go(1);
    while (pready !== 1'b1) begin
      go(1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    go(1);
  endtask : apb

  task automatic cmp_reg(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0);
    cmp("reg read", exp, rd & m);
    cmp("pslverr", {31'h0, ee}, {31'h0, er});
  endtask : cmp_reg

  task automatic do_reset();
    rst_b <= 1'b0;
    go(16);
    rst_b <= 1'b1;
    go(3);
  endtask : do_reset

  // bring the master to lock on a stream of the given kind
  task automatic master_lock(input logic s, input logic a);
    go(1);
    dlock <= 1'b0;
    go(4);
    dsd <= s;
    dasi <= a;
    dlock <= 1'b1;
    settle(20);
  endtask : master_lock

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {role, ipsel, cd_one, cd_two, bw, dlock, dasi, dsd, al, ac} = '0;
    cfg = 4'h0;
    void'($urandom(20505));
    go(16);
    rst_b <= 1'b1;
    settle(3);
    cmp("oe", 32'h0, oe);
    cmp("lock", 32'h0, lock);
    go(1);
    cmp_reg(DMSC_CTRL_OFS, 32'hFFFFFFFF, 32'h0, 1'b0);
    cmp_reg(8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b1, DMSC_CTRL_OFS, 32'h3);
    settle(1);
    cmp("loop mute", 32'h1, lmute);
    cmp("par mute", 32'h1, pmute);
    go(1);
    cmp_reg(DMSC_CTRL_OFS, 32'hFFFFFFFF, 32'h3, 1'b0);
    apb(1'b1, DMSC_CTRL_OFS, 32'h0);
    $display("test reset and registers done");
    role <= 1'b1;
    ipsel <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      sd = (k != 0);
      asi = (k == 2);
      master_lock(sd, asi);
      cmp("lock", 32'h1, lock);
      cmp("oe", 32'hF, oe);
      cmp("reclock out", 32'h1, dout[1]);
      cmp("loop", 32'h1, lrc);
      cmp("asi out", {31'h0, asi}, dout[3]);
      cmp("rate out", {31'h0, sd}, dout[2]);
      cmp("proc out", {31'h0, !asi}, dout[0]);
      cmp("proc en", {31'h0, !asi}, pen);
      cmp("input one", 32'h1, in1);
      go(1);
      cmp_reg(DMSC_STAT_OFS, 32'hC3, 32'hC3, 1'b0);
      for (int b = 0; b < 2; b++) begin
        bw <= b[0];
        settle(4);
        cmp("width", asi ? 0 : b, w20);
        for (int r = 0; r < 4; r++) begin
          go(1);
          v = $urandom;
          al <= v[0];
          ac <= v[1];
          settle(1);
          e = asi ? 0 : (sd && !b) ? (v[0] | v[1]) : v[0];
          cmp("luma", e, luma);
        end
        go(1);
      end
      dlock <= 1'b0;
      settle(3);
      cmp("lock", 32'h0, lock);
      cmp("reclock out", 32'h0, dout[1]);
      cmp("loop", 32'h0, lrc);
      cmp("asi out", 32'h0, dout[3]);
      cmp("proc en", 32'h0, pen);
    end
    $display("test master modes done");
    // three locks were lost above; any write to the loss register clears the count
    go(1);
    cmp_reg(DMSC_LOSS_OFS, 32'hFFFFFFFF, 32'h3, 1'b0);
    apb(1'b1, DMSC_LOSS_OFS, 32'h0);
    cmp_reg(DMSC_LOSS_OFS, 32'hFFFFFFFF, 32'h0, 1'b0);
    master_lock(1'b0, 1'b0);
    go(1);
    cd_one <= 1'b1;
    settle(4);
    cmp("lock", 32'h0, lock);
    cmp("par mute", 32'h1, pmute);
    go(1);
    ipsel <= 1'b0;
    settle(20);
    cmp("input one", 32'h0, in1);
    cmp("par mute", 32'h0, pmute);
    cmp("lock", 32'h1, lock);
    go(1);
    cd_two <= 1'b1;
    settle(4);
    cmp("par mute", 32'h1, pmute);
    go(1);
    {cd_one, cd_two} <= 2'b00;
    $display("test input select done");
    role <= 1'b0;
    dsd <= 1'b1;
    dasi <= 1'b0;
    cfg <= 4'b0111;
    go(4);
    do_reset();
    settle(20);
    cmp("oe", 32'h0, oe);
    cmp("loop", 32'h1, lrc);
    cmp("lock", 32'h1, lock);
    cmp("align", 32'h0, aen);
    cmp("decode", 32'h0, den);
    cmp("proc en", 32'h1, pen);
    go(1);
    cfg <= 4'b0101;
    settle(4);
    cmp("loop", 32'h0, lrc);
    go(1);
    cfg <= 4'b0110;
    settle(20);
    cmp("lock", 32'h0, lock);
    cmp("loop", 32'h1, lrc);
    cmp("deser", 32'h1, desen);
    go(1);
    cfg <= 4'b1100;
    dasi <= 1'b1;
    settle(20);
    cmp("align", 32'h1, aen);
    cmp("decode", 32'h1, den);
    cmp("proc en", 32'h0, pen);
    cmp("lock", 32'h1, lock);
    $display("test slave modes done");
    tally_and_finish();
  end
endmodule : deserializer_mode_status_control_tb
